// ---- include/sebfe_pkg.sv ----
// Shared constants, states and helpers for the serial memory bus front end
package sebfe_pkg;

   // ****************************************
   // Select word layout
   // ****************************************
   localparam logic [3:0] TYPE_MAIN     = 4'ha;
   localparam logic [3:0] TYPE_ID_PAGE  = 4'hb;
   localparam int         SEL_TYPE_MSB  = 7;
   localparam int         SEL_TYPE_LSB  = 4;
   localparam int         SEL_CS_MSB    = 3;
   localparam int         SEL_CS_LSB    = 1;
   localparam int         SEL_RW_BIT    = 0;
   localparam int         ADDR_LOCK_BIT = 7;

   // ****************************************
   // Bit slot counts
   // ****************************************
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_LAST  = 4'h7;
   localparam logic [3:0] ACK_SLOT  = 4'h8;
   localparam logic [3:0] ACK_DONE  = 4'h9;
   localparam logic [3:0] BIT_STEP  = 4'h1;

   // ****************************************
   // Exchange states, one-hot
   // ****************************************
   typedef enum logic [5:0] {
      ST_IDLE    = 6'h01,
      ST_SELECT  = 6'h02,
      ST_ADDRESS = 6'h04,
      ST_WRITE   = 6'h08,
      ST_READ    = 6'h10,
      ST_STANDBY = 6'h20
   } sebfe_state_type;

   // True when a received select word addresses this device
   function automatic logic selectMatches(input logic [7:0] word, input logic [2:0] straps);
      logic [3:0] kind;
      kind = word[SEL_TYPE_MSB:SEL_TYPE_LSB];
      return ((kind == TYPE_MAIN) || (kind == TYPE_ID_PAGE)) && (word[SEL_CS_MSB:SEL_CS_LSB] == straps);
   endfunction : selectMatches

endpackage : sebfe_pkg

// ---- include/sebfe_line_if.sv ----
// Sampled bus line events passed from the line sampler to the front end
`timescale 1ns/1ps
interface sebfe_line_if;
   logic sclRise;
   logic sclFall;
   logic sdaLevel;
   logic startSeen;
   logic stopSeen;

   modport sampler (output sclRise, output sclFall, output sdaLevel, output startSeen, output stopSeen);
   modport core (input sclRise, input sclFall, input sdaLevel, input startSeen, input stopSeen);
endinterface : sebfe_line_if

// ---- core/sebfe_line_sampler.sv ----
// Synchronises the two bus lines and finds clock edges, start and stop
`timescale 1ns/1ps
module sebfe_line_sampler (
   input  wire logic  clk,     // System clock
   input  wire logic  resetn,  // Async reset, active low
   input  wire logic  sclPin,  // Serial clock pin level
   input  wire logic  sdaPin,  // Serial data pin level
   sebfe_line_if.sampler lines // Line events out
);

   logic [2:0] sclPipe;
   logic [2:0] sdaPipe;
   logic [2:0] next_sclPipe;
   logic [2:0] next_sdaPipe;

   // ****************************************
   // Two-stage synchroniser plus one history stage
   // ****************************************
   always_comb begin
      next_sclPipe = {sclPipe[1:0], sclPin};
      next_sdaPipe = {sdaPipe[1:0], sdaPin};
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sclPipe <= 3'h7;
         sdaPipe <= 3'h7;
      end else begin
         sclPipe <= next_sclPipe;
         sdaPipe <= next_sdaPipe;
      end
   end

   // Stage 0 is only read by stage 1; detection uses stages 1 and 2
   assign lines.sclRise   = sclPipe[1] & ~sclPipe[2];
   assign lines.sclFall   = ~sclPipe[1] & sclPipe[2];
   assign lines.sdaLevel  = sdaPipe[1];
   assign lines.startSeen = sclPipe[1] & sclPipe[2] & sdaPipe[2] & ~sdaPipe[1];
   assign lines.stopSeen  = sclPipe[1] & sclPipe[2] & ~sdaPipe[2] & sdaPipe[1];

endmodule : sebfe_line_sampler

// ---- core/sebfe_front_end.sv ----
// Two-wire target front end: select decode, address decode, acknowledge
`timescale 1ns/1ps

module sebfe_front_end (
   input  wire logic       clk,                 // System clock, 40 MHz
   input  wire logic       resetn,              // Async reset, active low
   input  wire logic       sclPin,              // Serial clock pin
   input  wire logic       sdaPin,              // Serial data pin input
   output logic            sdaOut,              // Serial data output value
   output logic            sdaOe,               // Serial data pulls low when high
   input  wire logic       chip_select_strap_2, // Strap, upper bit
   input  wire logic       chip_select_strap_1, // Strap, middle bit
   input  wire logic       chip_select_strap_0, // Strap, lower bit
   input  wire logic       write_protect_input, // High refuses data writes
   input  wire logic       writeBusy,           // Programming cycle running
   input  wire logic [7:0] readData,            // Next byte to send
   output logic            selectStrobe,        // Select word accepted
   output logic            idPageAccess,        // Select targets identification page
   output logic            readMode,            // Select asked for a read
   output logic            addrStrobe,          // Address byte received
   output logic [7:0]      addrByte,            // Received address byte
   output logic            lockAccess,          // Address names the lock instruction
   output logic            dataStrobe,          // Write data byte accepted
   output logic [7:0]      dataByte,            // Received data byte
   output logic            readStrobe,          // Read byte taken for sending
   output logic            writeLaunch          // Start programming cycle
);

   sebfe_line_if lines ();

   sebfe_line_sampler sebfe_line_sampler_i (
      .clk    (clk),
      .resetn (resetn),
      .sclPin (sclPin),
      .sdaPin (sdaPin),
      .lines  (lines.sampler)
   );

   // ****************************************
   // Strap and protect synchronisers
   // ****************************************
   logic [3:0] pinMeta;
   logic [3:0] pinSync;
   logic [2:0] straps;
   logic       protect;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pinMeta <= 4'h0;
         pinSync <= 4'h0;
      end else begin
         pinMeta <= {write_protect_input, chip_select_strap_2, chip_select_strap_1, chip_select_strap_0};
         pinSync <= pinMeta;
      end
   end

   assign straps  = pinSync[2:0];
   assign protect = pinSync[3];

   // ****************************************
   // Exchange state
   // ****************************************
   sebfe_pkg::sebfe_state_type state;
   sebfe_pkg::sebfe_state_type next_state;
   logic [3:0] bitCnt;
   logic [3:0] next_bitCnt;
   logic [7:0] rxShift;
   logic [7:0] next_rxShift;
   logic [7:0] txShift;
   logic [7:0] next_txShift;
   logic       driveLow;
   logic       next_driveLow;
   logic       masterAck;
   logic       next_masterAck;
   logic       dataSeen;
   logic       next_dataSeen;
   logic       next_idPageAccess;
   logic       next_readMode;
   logic       next_selectStrobe;
   logic       next_addrStrobe;
   logic [7:0] next_addrByte;
   logic       next_lockAccess;
   logic       next_dataStrobe;
   logic [7:0] next_dataByte;
   logic       next_readStrobe;
   logic       next_writeLaunch;
   logic       active;

   assign active = (state == sebfe_pkg::ST_SELECT) || (state == sebfe_pkg::ST_ADDRESS) ||
                   (state == sebfe_pkg::ST_WRITE) || (state == sebfe_pkg::ST_READ);

   always_comb begin
      next_state        = state;
      next_bitCnt       = bitCnt;
      next_rxShift      = rxShift;
      next_txShift      = txShift;
      next_driveLow     = driveLow;
      next_masterAck    = masterAck;
      next_dataSeen     = dataSeen;
      next_idPageAccess = idPageAccess;
      next_readMode     = readMode;
      next_addrByte     = addrByte;
      next_lockAccess   = lockAccess;
      next_dataByte     = dataByte;
      next_selectStrobe = 1'b0;
      next_addrStrobe   = 1'b0;
      next_dataStrobe   = 1'b0;
      next_readStrobe   = 1'b0;
      next_writeLaunch  = 1'b0;
      if (lines.stopSeen && state != sebfe_pkg::ST_IDLE) begin
         // only in the slot after a data acknowledge
         // The stop's own clock rise has already stepped the counter once
         if (state == sebfe_pkg::ST_WRITE && dataSeen &&
             bitCnt == sebfe_pkg::BIT_FIRST + sebfe_pkg::BIT_STEP) begin
            next_writeLaunch = 1'b1;
         end
         next_state    = sebfe_pkg::ST_IDLE;
         next_driveLow = 1'b0;
         next_bitCnt   = sebfe_pkg::BIT_FIRST;
      end else if (lines.startSeen && !writeBusy) begin
         // start opens a select word, also as a repeated start
         next_state    = sebfe_pkg::ST_SELECT;
         next_bitCnt   = sebfe_pkg::BIT_FIRST;
         next_driveLow = 1'b0;
         next_dataSeen = 1'b0;
      end else if (active && lines.sclRise) begin
         if (bitCnt <= sebfe_pkg::BIT_LAST) begin
            // capture on rise, first bit lands at the top
            if (state != sebfe_pkg::ST_READ) begin
               next_rxShift = {rxShift[6:0], lines.sdaLevel};
            end
            next_bitCnt = bitCnt + sebfe_pkg::BIT_STEP;
         end else if (bitCnt == sebfe_pkg::ACK_SLOT) begin
            next_masterAck = ~lines.sdaLevel;
            next_bitCnt    = sebfe_pkg::ACK_DONE;
         end
      end else if (active && lines.sclFall) begin
         if (bitCnt == sebfe_pkg::ACK_SLOT) begin
            // acknowledge decision for the ninth pulse
            case (state)
               sebfe_pkg::ST_SELECT: begin
                  if (sebfe_pkg::selectMatches(rxShift, straps)) begin
                     next_driveLow     = 1'b1;
                     next_selectStrobe = 1'b1;
                     // type field picks array or page
                     next_idPageAccess = rxShift[sebfe_pkg::SEL_TYPE_LSB];
                     next_readMode     = rxShift[sebfe_pkg::SEL_RW_BIT];
                  end else begin
                     next_driveLow = 1'b0;
                     next_state    = sebfe_pkg::ST_STANDBY;
                  end
               end
               sebfe_pkg::ST_ADDRESS: begin
                  next_driveLow   = 1'b1;
                  next_addrStrobe = 1'b1;
                  // full byte kept for the main array
                  next_addrByte   = rxShift;
                  next_lockAccess = idPageAccess & rxShift[sebfe_pkg::ADDR_LOCK_BIT];
               end
               sebfe_pkg::ST_WRITE: begin
                  next_driveLow = ~protect;
                  if (!protect) begin
                     next_dataStrobe = 1'b1;
                     next_dataByte   = rxShift;
                     next_dataSeen   = 1'b1;
                  end
               end
               sebfe_pkg::ST_READ: begin
                  next_driveLow = 1'b0;
               end
               default: begin
                  next_driveLow = 1'b0;
               end
            endcase
         end else if (bitCnt == sebfe_pkg::ACK_DONE) begin
            next_bitCnt   = sebfe_pkg::BIT_FIRST;
            next_driveLow = 1'b0;
            case (state)
               sebfe_pkg::ST_SELECT: begin
                  if (readMode) begin
                     next_state      = sebfe_pkg::ST_READ;
                     next_txShift    = readData;
                     next_driveLow   = ~readData[7];
                     next_readStrobe = 1'b1;
                  end else begin
                     next_state = sebfe_pkg::ST_ADDRESS;
                  end
               end
               sebfe_pkg::ST_ADDRESS: begin
                  next_state = sebfe_pkg::ST_WRITE;
               end
               sebfe_pkg::ST_READ: begin
                  // A missing controller acknowledge ends the read
                  if (masterAck) begin
                     next_txShift    = readData;
                     next_driveLow   = ~readData[7];
                     next_readStrobe = 1'b1;
                  end else begin
                     next_state = sebfe_pkg::ST_STANDBY;
                  end
               end
               default: begin
                  next_state = state;
               end
            endcase
         end else if (state == sebfe_pkg::ST_READ && bitCnt != sebfe_pkg::BIT_FIRST) begin
            // Shift on the falling edge so data never moves while clock is high
            next_txShift  = {txShift[6:0], 1'b0};
            next_driveLow = ~txShift[6];
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state        <= sebfe_pkg::ST_IDLE;
         bitCnt       <= sebfe_pkg::BIT_FIRST;
         rxShift      <= 8'h00;
         txShift      <= 8'h00;
         driveLow     <= 1'b0;
         masterAck    <= 1'b0;
         dataSeen     <= 1'b0;
         idPageAccess <= 1'b0;
         readMode     <= 1'b0;
         addrByte     <= 8'h00;
         lockAccess   <= 1'b0;
         dataByte     <= 8'h00;
         selectStrobe <= 1'b0;
         addrStrobe   <= 1'b0;
         dataStrobe   <= 1'b0;
         readStrobe   <= 1'b0;
         writeLaunch  <= 1'b0;
      end else begin
         state        <= next_state;
         bitCnt       <= next_bitCnt;
         rxShift      <= next_rxShift;
         txShift      <= next_txShift;
         driveLow     <= next_driveLow;
         masterAck    <= next_masterAck;
         dataSeen     <= next_dataSeen;
         idPageAccess <= next_idPageAccess;
         readMode     <= next_readMode;
         addrByte     <= next_addrByte;
         lockAccess   <= next_lockAccess;
         dataByte     <= next_dataByte;
         selectStrobe <= next_selectStrobe;
         addrStrobe   <= next_addrStrobe;
         dataStrobe   <= next_dataStrobe;
         readStrobe   <= next_readStrobe;
         writeLaunch  <= next_writeLaunch;
      end
   end

   // ****************************************
   // Pin drive
   // ****************************************
   // pull low or release only, no clock output
   assign sdaOut = 1'b0;
   assign sdaOe  = driveLow;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   AST_START_OPENS: assert property (
      lines.startSeen && !writeBusy && !lines.stopSeen |=> state == sebfe_pkg::ST_SELECT && bitCnt == 4'h0 && !sdaOe)
      else $error("start did not open a select word");

   AST_BUSY_DEAF: assert property (
      writeBusy && state == sebfe_pkg::ST_IDLE |=> state == sebfe_pkg::ST_IDLE && !sdaOe)
      else $error("bus answered during programming");

   AST_STOP_IDLE: assert property (
      lines.stopSeen |=> state == sebfe_pkg::ST_IDLE ##1 !sdaOe)
      else $error("stop did not end the exchange");

   AST_STOP_LAUNCH: assert property (
      lines.stopSeen && state == sebfe_pkg::ST_WRITE && dataSeen && bitCnt == 4'h1 |=> writeLaunch ##1 !writeLaunch)
      else $error("write stop did not launch one programming pulse");

   AST_NO_STRAY_LAUNCH: assert property (
      writeLaunch |-> $past(lines.stopSeen) && $past(state) == sebfe_pkg::ST_WRITE)
      else $error("programming launched without a write stop");

   AST_RISE_CAPTURE: assert property (
      lines.sclRise && active && bitCnt < 4'h8 && state != sebfe_pkg::ST_READ && !lines.startSeen && !lines.stopSeen
      |=> rxShift[0] == $past(lines.sdaLevel) && bitCnt == $past(bitCnt) + 4'h1)
      else $error("bit not captured on clock rise");

   AST_SELECT_ACK: assert property (
      state == sebfe_pkg::ST_SELECT && lines.sclFall && bitCnt == 4'h8 && !lines.stopSeen && !lines.startSeen &&
      sebfe_pkg::selectMatches(rxShift, straps) |=> sdaOe && selectStrobe && readMode == $past(rxShift[0]))
      else $error("matching select word not acknowledged");

   AST_MISMATCH_STANDBY: assert property (
      state == sebfe_pkg::ST_SELECT && lines.sclFall && bitCnt == 4'h8 && !lines.stopSeen && !lines.startSeen &&
      !sebfe_pkg::selectMatches(rxShift, straps) |=> state == sebfe_pkg::ST_STANDBY && !sdaOe)
      else $error("mismatched select word not released");

   AST_PROTECT_NACK: assert property (
      state == sebfe_pkg::ST_WRITE && lines.sclFall && bitCnt == 4'h8 && protect && !lines.stopSeen &&
      !lines.startSeen |=> !sdaOe && !dataStrobe)
      else $error("protected data byte acknowledged");

   AST_READ_RELEASE: assert property (
      state == sebfe_pkg::ST_READ && bitCnt == 4'h8 && lines.sclFall |=> !sdaOe)
      else $error("read byte not released for controller acknowledge");

   AST_LOCK_DECODE: assert property (
      addrStrobe |-> lockAccess == (idPageAccess && addrByte[7]))
      else $error("lock decode wrong");

endmodule : sebfe_front_end

// ---- verif/sebfe_bus_master.sv ----
// Behavioural two-wire bus controller that drives the front end
`timescale 1ns/1ps
module sebfe_bus_master (
   input  wire logic clk,     // System clock, paces the bus
   input  wire logic sdaWire, // Resolved data line level
   output logic      sclPin,  // Serial clock, idles high
   output logic      sdaLow   // High pulls the data line low
);
   initial begin
      sclPin = 1'b1;
      sdaLow = 1'b0;
   end

   task automatic waitClk(input int n);
      repeat (n) @(posedge clk);
   endtask : waitClk

   // data moves only in the low phase
   // Four clocks low, four high: one bus period is 200 ns
   task automatic slot(input logic b, output logic seen);
      waitClk(2);
      sdaLow <= ~b;
      waitClk(2);
      sclPin <= 1'b1;
      waitClk(2);
      seen = sdaWire;
      waitClk(2);
      sclPin <= 1'b0;
   endtask : slot

   // start opens every instruction
   // Also serves as repeated start when the clock is low
   task automatic start();
      sdaLow <= 1'b0;
      // Let a target's acknowledge drop before the clock rises, or it reads as a stop
      waitClk(4);
      sclPin <= 1'b1;
      waitClk(4);
      sdaLow <= 1'b1;
      waitClk(4);
      sclPin <= 1'b0;
   endtask : start

   task automatic stop();
      waitClk(2);
      sdaLow <= 1'b1;
      waitClk(2);
      sclPin <= 1'b1;
      waitClk(4);
      sdaLow <= 1'b0;
      // Long enough for the launch pulse to be counted before a test judges it
      waitClk(6);
   endtask : stop

   // most significant first, then release for the ack
   task automatic writeByte(input logic [7:0] v, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         slot(v[i], s);
      end
      slot(1'b1, s);
      ack = ~s;
   endtask : writeByte

   // controller acknowledges a read byte when asked
   task automatic readByte(input logic ackIt, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         slot(1'b1, v[i]);
      end
      slot(~ackIt, s);
   endtask : readByte
endmodule : sebfe_bus_master

// ---- verif/test_serial_eeprom_bus_front_end.sv ----
// Self-checking bench for the serial memory bus front end
`timescale 1ns/1ps
module test_serial_eeprom_bus_front_end;
   logic       clk = 1'b0;
   logic       resetn = 1'b0;
   logic       sclPin, sdaLow, sdaOut, sdaOe;
   wire        sdaPin;
   logic [2:0] strap = 3'h5;
   logic       wp = 1'b0;
   logic       writeBusy = 1'b0;
   logic [7:0] readData = 8'h96;
   logic       selectStrobe, idPageAccess, readMode, addrStrobe, lockAccess;
   logic       dataStrobe, readStrobe, writeLaunch;
   logic [7:0] addrByte, dataByte;
   int         failures = 0, nTests = 0, cycles = 0;
   int         nSel = 0, nAddr = 0, nData = 0, nRead = 0, nLaunch = 0;

   // Pull-up on the data line; either party may pull it low
   assign sdaPin = ~(sdaLow | (sdaOe & ~sdaOut));

   always #12.5 clk = ~clk;

   sebfe_bus_master sebfe_bus_master_i (.clk(clk), .sdaWire(sdaPin), .sclPin(sclPin), .sdaLow(sdaLow));

   sebfe_front_end sebfe_front_end_i (
      .clk(clk), .resetn(resetn), .sclPin(sclPin), .sdaPin(sdaPin), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .chip_select_strap_2(strap[2]), .chip_select_strap_1(strap[1]), .chip_select_strap_0(strap[0]),
      .write_protect_input(wp), .writeBusy(writeBusy), .readData(readData),
      .selectStrobe(selectStrobe), .idPageAccess(idPageAccess), .readMode(readMode),
      .addrStrobe(addrStrobe), .addrByte(addrByte), .lockAccess(lockAccess), .dataStrobe(dataStrobe),
      .dataByte(dataByte), .readStrobe(readStrobe), .writeLaunch(writeLaunch));

   // Pulses are counted so a test can judge how many arrived
   always @(posedge clk) begin
      cycles++;
      if (selectStrobe === 1'b1) nSel++;
      if (addrStrobe === 1'b1) nAddr++;
      if (dataStrobe === 1'b1) nData++;
      if (readStrobe === 1'b1) nRead++;
      if (writeLaunch === 1'b1) nLaunch++;
      if (cycles == 20000) begin
         failures++;
         print_verdict();
      end
   end

   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", nTests, failures);
      if (failures == 0 && nTests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic testWrite();
      logic a;
      int   s0 = nSel, a0 = nAddr, d0 = nData, l0 = nLaunch;
      sebfe_bus_master_i.start();
      sebfe_bus_master_i.writeByte({4'ha, strap, 1'b0}, a);
      check("select ack", a, 1);
      check("read mode", readMode, 0);
      sebfe_bus_master_i.writeByte(8'ha5, a);
      check("address ack", a, 1);
      check("address byte", addrByte, 8'ha5);
      sebfe_bus_master_i.writeByte(8'h3c, a);
      check("data ack", a, 1);
      check("data byte", dataByte, 8'h3c);
      sebfe_bus_master_i.stop();
      check("launches", nLaunch - l0, 1);
      check("select strobes", nSel - s0, 1);
      check("address strobes", nAddr - a0, 1);
      check("data strobes", nData - d0, 1);
      check("bus released", sdaOe, 0);
      $display("test write done");
   endtask : testWrite

   task automatic testDecode();
      logic a;
      for (int t = 0; t < 16; t++) begin
         sebfe_bus_master_i.start();
         sebfe_bus_master_i.writeByte({t[3:0], strap, 1'b0}, a);
         sebfe_bus_master_i.stop();
         check("type ack", a, (t == 10) || (t == 11));
      end
      sebfe_bus_master_i.start();
      sebfe_bus_master_i.writeByte({4'ha, strap ^ 3'h1, 1'b0}, a);
      check("foreign chip select", a, 0);
      // A matching word without a fresh start must still be ignored
      sebfe_bus_master_i.writeByte({4'ha, strap, 1'b0}, a);
      check("standby", a, 0);
      sebfe_bus_master_i.stop();
      $display("test decode done");
   endtask : testDecode

   task automatic testIdPage();
      logic a;
      int   l0 = nLaunch;
      sebfe_bus_master_i.start();
      sebfe_bus_master_i.writeByte({4'hb, strap, 1'b0}, a);
      sebfe_bus_master_i.writeByte(8'h80, a);
      check("page select", idPageAccess, 1);
      check("lock decode", lockAccess, 1);
      sebfe_bus_master_i.start();
      sebfe_bus_master_i.writeByte({4'hb, strap, 1'b0}, a);
      sebfe_bus_master_i.writeByte(8'h75, a);
      check("page address", {lockAccess, addrByte}, 9'h075);
      sebfe_bus_master_i.stop();
      check("no launch without data", nLaunch - l0, 0);
      $display("test id page done");
   endtask : testIdPage

   task automatic testProtect();
      logic a1, a2, a3;
      int   d0 = nData, l0 = nLaunch;
      wp <= 1'b1;
      sebfe_bus_master_i.start();
      sebfe_bus_master_i.writeByte({4'ha, strap, 1'b0}, a1);
      sebfe_bus_master_i.writeByte(8'h10, a2);
      sebfe_bus_master_i.writeByte(8'h55, a3);
      sebfe_bus_master_i.stop();
      wp <= 1'b0;
      check("protected acks", {a1, a2, a3}, 3'b110);
      check("protected data strobes", nData - d0, 0);
      check("protected launches", nLaunch - l0, 0);
      $display("test protect done");
   endtask : testProtect

   task automatic testRead();
      logic       a;
      logic [7:0] v;
      int         r0 = nRead;
      sebfe_bus_master_i.start();
      sebfe_bus_master_i.writeByte({4'ha, strap, 1'b0}, a);
      sebfe_bus_master_i.writeByte(8'h20, a);
      sebfe_bus_master_i.start();
      sebfe_bus_master_i.writeByte({4'ha, strap, 1'b1}, a);
      check("read select ack", {a, readMode}, 2'b11);
      sebfe_bus_master_i.readByte(1'b1, v);
      check("first read byte", v, 8'h96);
      sebfe_bus_master_i.readByte(1'b0, v);
      check("last read byte", v, 8'h96);
      sebfe_bus_master_i.stop();
      check("bytes loaded", nRead - r0, 2);
      check("released after read", sdaOe, 0);
      $display("test read done");
   endtask : testRead

   task automatic testBusy();
      logic a;
      writeBusy <= 1'b1;
      sebfe_bus_master_i.start();
      sebfe_bus_master_i.writeByte({4'ha, strap, 1'b0}, a);
      sebfe_bus_master_i.stop();
      writeBusy <= 1'b0;
      check("busy ignores bus", a, 0);
      $display("test busy done");
   endtask : testBusy

   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      testWrite();
      testDecode();
      testIdPage();
      testProtect();
      testRead();
      testBusy();
      testWrite();
      print_verdict();
   end
endmodule : test_serial_eeprom_bus_front_end
